/* File: flash_self_program_sequencer_test.sv */
module flash_self_program_sequencer_test
  import fsps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic flash_busy;
  logic flash_erase;
  logic [23:0] flash_erase_addr;
  logic flash_prog_we;
  logic [23:0] flash_prog_addr;
  logic [23:0] flash_prog_data;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rdat;

  always #5 sys_clk = ~sys_clk;

  fsps_sequencer uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_busy(flash_busy), .flash_erase(flash_erase),
    .flash_erase_addr(flash_erase_addr), .flash_prog_we(flash_prog_we),
    .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data)
  );

  fsps_flash_model flash (
    .sys_clk(sys_clk), .clk_en(clk_en), .flash_erase(flash_erase),
    .flash_erase_addr(flash_erase_addr), .flash_prog_we(flash_prog_we),
    .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One Avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      check("waitrequest timeout", 32'h0000_0001, 32'h0000_0000);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask

  // Key pair, then launch; no interrupts exist to mask here
  task automatic unlock_launch(input logic [7:0] k1, input logic [7:0] k2,
                               input logic mid, input logic [15:0] code);
    wr(OFS_KEY, {8'h00, k1});
    if (mid) begin
      wr(OFS_PAGE, 16'h0000);
    end
    wr(OFS_KEY, {8'h00, k2});
    wr(OFS_CONTROL, code | 16'h8000);
    repeat (2) @(posedge sys_clk);
  endtask

  // Poll the launch bit; bounded so a stuck operation shows as a mismatch
  task automatic wait_done(input logic [15:0] code);
    int n;
    n = 0;
    do begin
      rd(OFS_CONTROL, rdat);
      n++;
    end while (rdat[LAUNCH_BIT] === 1'b1 && n < 2000);
    check("launch cleared", rdat, {16'h0000, code});
  endtask

  initial begin
    #200000;
    check("watchdog", 32'h0000_0001, 32'h0000_0000);
    end_sim();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFS_STATUS, rdat);
    check("status after reset", rdat, 32'h0000_0000);
    rd(5'h1c, rdat);
    check("unmapped read", rdat, 32'h0000_0000);
    // Wrong order (0xAA given first), and a foreign write between keys
    unlock_launch(KEY_SECOND, KEY_FIRST, 1'b0, OP_PAGE_ERASE);
    rd(OFS_CONTROL, rdat);
    check("bad order control", rdat, {16'h0000, OP_PAGE_ERASE});
    unlock_launch(KEY_FIRST, KEY_SECOND, 1'b1, OP_PAGE_ERASE);
    rd(OFS_STATUS, rdat);
    check("split keys refused", rdat, 32'h0000_0004);
    check("no erase yet", {16'h0000, flash.erase_cnt}, 32'h0000_0000);
    // Keys given but an unknown code: launch refused, code bits kept
    unlock_launch(KEY_FIRST, KEY_SECOND, 1'b0, 16'h4003);
    rd(OFS_CONTROL, rdat);
    check("bad code control", rdat, 32'h0000_4003);
    // Page erase with page base from pointer plus low store
    wr(OFS_PAGE, 16'h0012);
    wr(OFS_OFFSET, 16'h1234);
    wr(OFS_STORE_LOW, 16'h0000);
    wr(OFS_STATUS, 16'h000c);
    wr(OFS_KEY, {8'h00, KEY_FIRST});
    wr(OFS_KEY, {8'h00, KEY_SECOND});
    rd(OFS_STATUS, rdat);
    check("armed", rdat, 32'h0000_0002);
    wr(OFS_CONTROL, OP_PAGE_ERASE | 16'h8000);
    repeat (2) @(posedge sys_clk);
    check("busy", {31'h0, flash_busy}, 32'h0000_0001);
    rd(OFS_CONTROL, rdat);
    check("launch held", rdat, 32'h0000_c042);
    // Clock enable low must freeze the erase; the total length still has to match
    clk_en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check("frozen erase", {30'h0, flash_busy, flash_erase}, 32'h0000_0003);
    clk_en <= 1'b1;
    wr(OFS_CONTROL, OP_ROW_PROG | 16'h8000);
    wait_done(OP_PAGE_ERASE);
    check("erase cycles", {16'h0000, flash.erase_cnt}, 32'(ERASE_CYCLES));
    check("erase addr", {8'h00, flash.erase_addr}, 32'h0012_1000);
    rd(OFS_STATUS, rdat);
    check("done and refused", rdat, 32'h0000_000c);
    // Fill a whole row of latches, offset advancing after each high store
    wr(OFS_PAGE, 16'h0003);
    wr(OFS_OFFSET, 16'h0180);
    for (int i = 0; i < 64; i++) begin
      wr(OFS_STORE_LOW, 16'h1000 + 16'(i));
      wr(OFS_STORE_HIGH, {8'h00, 8'(i) ^ 8'h5a});
    end
    rd(OFS_OFFSET, rdat);
    check("offset advanced", rdat, 32'h0000_0200);
    wr(OFS_STATUS, 16'h000c);
    unlock_launch(KEY_FIRST, KEY_SECOND, 1'b0, OP_ROW_PROG);
    wait_done(OP_ROW_PROG);
    check("prog cycles", {16'h0000, flash.prog_cnt}, 32'(ROW_WORDS));
    check("row base", {8'h00, flash.first_addr}, 32'h0003_0180);
    check("no erase by program", {16'h0000, flash.erase_cnt}, 32'(ERASE_CYCLES));
    for (int i = 0; i < 64; i++) begin
      check("latch", 32'(flash.mem[i]), {8'h00, 8'(i) ^ 8'h5a, 16'h1000 + 16'(i)});
    end
    rd(OFS_STATUS, rdat);
    check("program done", rdat, 32'h0000_0008);
    end_sim();
  end
endmodule

/* File: fsps_flash_model.sv */
module fsps_flash_model (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic flash_erase,
  input wire logic [23:0] flash_erase_addr,
  input wire logic flash_prog_we,
  input wire logic [23:0] flash_prog_addr,
  input wire logic [23:0] flash_prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] erase_cnt = 16'h0000;
  logic [23:0] erase_addr = 24'h00_0000;
  logic [15:0] prog_cnt = 16'h0000;
  logic [23:0] first_addr = 24'h00_0000;
  logic prog_last = 1'b0;
  logic [23:0] mem [0:63];

  // Array only follows the strobes; the block alone decides how long they last
  // Shares the block's clock enable, so a frozen cycle is no array cycle
  always @(posedge sys_clk) begin
    if (clk_en === 1'b1) begin
      if (flash_erase === 1'b1) begin
        erase_cnt <= erase_cnt + 16'h0001;
        erase_addr <= flash_erase_addr;
      end
      if (flash_prog_we === 1'b1) begin
        if (!prog_last) begin
          first_addr <= flash_prog_addr;
        end
        prog_cnt <= prog_cnt + 16'h0001;
        mem[flash_prog_addr[6:1]] <= flash_prog_data;
      end
      prog_last <= flash_prog_we;
    end
  end
endmodule

/* File: fsps_key_unlock.sv */
module fsps_key_unlock
  import fsps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic other_wr,
  output logic armed
);
  typedef enum logic [1:0] {
    FSPS_KEY_IDLE = 2'b00,
    FSPS_KEY_HALF = 2'b01,
    FSPS_KEY_ARMED = 2'b10
  } fsps_key_t;

  fsps_key_t key_state;
  fsps_key_t next_key_state;

  // Any stray write in between breaks the sequence
  always_comb begin
    next_key_state = key_state;
    unique case (key_state)
      FSPS_KEY_IDLE: begin
        if (key_wr && key_data == KEY_FIRST) next_key_state = FSPS_KEY_HALF; // [RULE5]
      end
      FSPS_KEY_HALF: begin
        if (key_wr) begin
          next_key_state = (key_data == KEY_SECOND) ? FSPS_KEY_ARMED : FSPS_KEY_IDLE; // [RULE5]
        end else if (other_wr) begin
          next_key_state = FSPS_KEY_IDLE;
        end
      end
      FSPS_KEY_ARMED: begin
        if (key_wr || other_wr) next_key_state = FSPS_KEY_IDLE;
      end
      default: next_key_state = FSPS_KEY_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      key_state <= FSPS_KEY_IDLE;
    end else if (clk_en) begin
      key_state <= next_key_state;
    end
  end

  assign armed = (key_state == FSPS_KEY_ARMED);

  a_key_order: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    clk_en && key_wr && key_data == KEY_SECOND && key_state == FSPS_KEY_HALF |=> armed)
    else $error("key pair did not arm");
endmodule

/* File: fsps_pkg.sv */
package fsps_pkg;
  // Clock and self-timed operation lengths
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_US = 20;
  localparam int PROG_TIME_US = 2;
  localparam logic [11:0] ERASE_CYCLES =
    12'((ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PROG_CYCLES =
    12'((PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_KEY = 5'h04;
  localparam logic [4:0] OFS_PAGE = 5'h08;
  localparam logic [4:0] OFS_OFFSET = 5'h0c;
  localparam logic [4:0] OFS_STORE_LOW = 5'h10;
  localparam logic [4:0] OFS_STORE_HIGH = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // Control register contents
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int LAUNCH_BIT = 15;
  localparam logic [15:0] OP_MASK = 16'h7fff;
  localparam logic [15:0] OP_PAGE_ERASE = 16'h4042;
  localparam logic [15:0] OP_ROW_PROG = 16'h4001;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_DONE = 3;

  // Array geometry, addresses in program counter units (two per word)
  localparam int PAGE_WORDS = 512;
  localparam int PAGE_BYTES = 1536;
  localparam int ROW_WORDS = 64;
  localparam int ROW_BYTES = 192;
  localparam int PAGE_LSB = 10;
  localparam int ROW_LSB = 7;
  localparam logic [15:0] OFFSET_STEP = 16'h0002;
  localparam logic [6:0] ROW_WORDS_7 = 7'h40;

  typedef enum logic [1:0] {
    FSPS_IDLE = 2'b00,
    FSPS_ERASE = 2'b01,
    FSPS_PROG = 2'b10,
    FSPS_WAIT = 2'b11
  } fsps_state_t;

  // Merge the low two byte lanes of a bus write into a 16-bit register
  function automatic logic [15:0] fsps_merge(input logic [15:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
    fsps_merge = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
  endfunction
endpackage

/* File: fsps_sequencer.sv */
// What the document requires of this block and of the software using it
// RULE1: Erase clears one whole 512-word page
// RULE2: Program writes one 64-word row from latches
// RULE3: Control value 0x4042 selects page erase
// RULE4: Erase address from page pointer plus low store
// RULE5: Keys 0x55 then 0xAA before any start
// RULE6: Launch bit after unlock starts the operation
// RULE7: Software runs two idle instructions after launch
// RULE8: Operations time themselves and end alone
// RULE9: No separate flash address registers exist
// RULE10: No completion interrupt is raised
// RULE11: Low then high store, offset advances after high
// RULE12: Software masks interrupts around unlock and launch
// RULE13: Launch bit stays set until operation completes
module fsps_sequencer
  import fsps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic flash_busy,
  output logic flash_erase,
  output logic [23:0] flash_erase_addr,
  output logic flash_prog_we,
  output logic [23:0] flash_prog_addr,
  output logic [23:0] flash_prog_data
);
  // Register and sequencer state
  fsps_state_t state;
  fsps_state_t next_state;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [7:0] tbl_page;
  logic [7:0] next_tbl_page;
  logic [15:0] tbl_offset;
  logic [15:0] next_tbl_offset;
  logic [23:0] erase_base;
  logic [23:0] next_erase_base;
  logic [16:0] row_base;
  logic [16:0] next_row_base;
  logic refused;
  logic next_refused;
  logic done;
  logic next_done;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [5:0] idx;
  logic [5:0] next_idx;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_busy;
  logic next_erase;
  logic [23:0] next_erase_addr;
  logic next_prog_we;
  logic [23:0] next_prog_addr;
  logic [23:0] next_prog_data;

  // Bus decode, valid only in the cycle the answer is given
  logic acc_wr;
  logic wr_ctrl;
  logic wr_key;
  logic wr_low;
  logic wr_high;
  logic wr_other;
  logic [15:0] ctrl_merged;
  logic [15:0] store_merged;
  logic [15:0] page_merged;
  logic [23:0] table_addr;
  logic key_armed;
  logic start_ok;
  logic [23:0] latch_rd;

  assign acc_wr = avs_write && !avs_waitrequest;
  assign wr_ctrl = acc_wr && avs_address == OFS_CONTROL;
  assign wr_key = acc_wr && avs_address == OFS_KEY;
  assign wr_low = acc_wr && avs_address == OFS_STORE_LOW;
  assign wr_high = acc_wr && avs_address == OFS_STORE_HIGH;
  assign wr_other = acc_wr && !wr_key && !wr_ctrl;
  assign ctrl_merged = fsps_merge(ctrl, avs_writedata, avs_byteenable);
  assign store_merged = fsps_merge(16'h0000, avs_writedata, avs_byteenable);
  assign page_merged = fsps_merge({8'h00, tbl_page}, avs_writedata, avs_byteenable);
  // Flash address is only ever page pointer plus table offset
  assign table_addr = {tbl_page, tbl_offset}; // [RULE9]

  // Start is honoured only with keys given, idle, and a known code
  assign start_ok = wr_ctrl && ctrl_merged[LAUNCH_BIT] && key_armed &&
                    state == FSPS_IDLE &&
                    ((ctrl_merged & OP_MASK) == OP_PAGE_ERASE ||
                     (ctrl_merged & OP_MASK) == OP_ROW_PROG); // [RULE5] [RULE6]

  fsps_key_unlock u_key (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .key_wr(wr_key),
    .key_data(avs_writedata[7:0]),
    .other_wr(wr_ctrl || wr_other),
    .armed(key_armed)
  );

  fsps_write_latch u_latch (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .low_wr(wr_low),
    .high_wr(wr_high),
    .wr_idx(tbl_offset[ROW_LSB-1:1]),
    .wr_data(store_merged),
    .rd_idx(idx),
    .rd_data(latch_rd)
  );

  // One wait cycle per access, so every access answers on the second edge
  always_comb begin
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFS_CONTROL: next_readdata = {16'h0000, ctrl};
        OFS_PAGE: next_readdata = {24'h00_0000, tbl_page};
        OFS_OFFSET: next_readdata = {16'h0000, tbl_offset};
        OFS_STATUS: next_readdata = {28'h000_0000, done, refused, key_armed,
                                     state != FSPS_IDLE};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // Pointer registers and the table stores
  always_comb begin
    next_tbl_page = tbl_page;
    next_tbl_offset = tbl_offset;
    next_erase_base = erase_base;
    next_row_base = row_base;
    if (acc_wr && avs_address == OFS_PAGE) begin
      next_tbl_page = page_merged[7:0];
    end
    if (acc_wr && avs_address == OFS_OFFSET) begin
      next_tbl_offset = fsps_merge(tbl_offset, avs_writedata, avs_byteenable);
    end
    if (wr_low) begin
      // Low store also fixes the page to erase and the row to program
      next_erase_base = {table_addr[23:PAGE_LSB], {PAGE_LSB{1'b0}}}; // [RULE4] [RULE1]
      next_row_base = table_addr[23:ROW_LSB]; // [RULE2]
    end
    if (wr_high) begin
      next_tbl_offset = 16'(tbl_offset + OFFSET_STEP); // [RULE11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      tbl_page <= 8'h00;
      tbl_offset <= 16'h0000;
      erase_base <= 24'h00_0000;
      row_base <= 17'h0_0000;
    end else if (clk_en) begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      tbl_page <= next_tbl_page;
      tbl_offset <= next_tbl_offset;
      erase_base <= next_erase_base;
      row_base <= next_row_base;
    end
  end

  // Sequencer: self-timed, no timer or software needed to finish
  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_refused = refused;
    next_done = done;
    next_cnt = cnt;
    next_idx = idx;
    next_erase = 1'b0;
    next_erase_addr = flash_erase_addr;
    next_prog_we = 1'b0;
    next_prog_addr = flash_prog_addr;
    next_prog_data = flash_prog_data;
    // Software clears sticky status by writing ones
    if (acc_wr && avs_address == OFS_STATUS) begin
      if (avs_byteenable[0] && avs_writedata[ST_REFUSED]) next_refused = 1'b0;
      if (avs_byteenable[0] && avs_writedata[ST_DONE]) next_done = 1'b0;
    end
    // Control writes change the code only while idle; launch needs the keys
    if (wr_ctrl && state == FSPS_IDLE) begin
      next_ctrl = {start_ok, ctrl_merged[14:0]}; // [RULE6]
      if (ctrl_merged[LAUNCH_BIT] && !start_ok) next_refused = 1'b1;
    end else if (wr_ctrl) begin
      next_refused = 1'b1;
    end
    unique case (state)
      FSPS_IDLE: begin
        if (start_ok && (ctrl_merged & OP_MASK) == OP_PAGE_ERASE) begin // [RULE3]
          next_state = FSPS_ERASE;
          next_cnt = ERASE_CYCLES; // [RULE8]
          next_erase = 1'b1;
          next_erase_addr = erase_base; // [RULE4] [RULE1]
        end else if (start_ok) begin
          next_state = FSPS_PROG;
          next_idx = 6'h00;
        end
      end
      FSPS_ERASE: begin
        if (cnt == 12'h001) begin
          next_state = FSPS_IDLE;
          next_ctrl[LAUNCH_BIT] = 1'b0; // [RULE13]
          next_done = 1'b1;
        end else begin
          next_cnt = 12'(cnt - 12'h001); // [RULE8]
          next_erase = 1'b1;
        end
      end
      FSPS_PROG: begin
        // Stream the whole row, one latch per cycle
        next_prog_we = 1'b1; // [RULE2]
        next_prog_addr = {row_base, idx, 1'b0};
        next_prog_data = latch_rd;
        next_idx = 6'(idx + 6'h01);
        if (idx == 6'h3f) begin
          next_state = FSPS_WAIT;
          next_cnt = PROG_CYCLES; // [RULE8]
        end
      end
      FSPS_WAIT: begin
        if (cnt == 12'h001) begin
          next_state = FSPS_IDLE;
          next_ctrl[LAUNCH_BIT] = 1'b0; // [RULE13]
          next_done = 1'b1;
        end else begin
          next_cnt = 12'(cnt - 12'h001);
        end
      end
    endcase
    // Status set wins over a clear in the same cycle
    if (state != FSPS_IDLE && next_state == FSPS_IDLE) next_done = 1'b1;
    next_busy = next_state != FSPS_IDLE; // [RULE13]
  end

  // Completion is visible only by polling; no interrupt line exists
  always_ff @(posedge sys_clk) begin // [RULE10]
    if (!rst_n) begin
      state <= FSPS_IDLE;
      ctrl <= CTRL_RESET;
      refused <= 1'b0;
      done <= 1'b0;
      cnt <= 12'h000;
      idx <= 6'h00;
      flash_busy <= 1'b0;
      flash_erase <= 1'b0;
      flash_erase_addr <= 24'h00_0000;
      flash_prog_we <= 1'b0;
      flash_prog_addr <= 24'h00_0000;
      flash_prog_data <= 24'h00_0000;
    end else if (clk_en) begin
      state <= next_state;
      ctrl <= next_ctrl;
      refused <= next_refused;
      done <= next_done;
      cnt <= next_cnt;
      idx <= next_idx;
      flash_busy <= next_busy;
      flash_erase <= next_erase;
      flash_erase_addr <= next_erase_addr;
      flash_prog_we <= next_prog_we;
      flash_prog_addr <= next_prog_addr;
      flash_prog_data <= next_prog_data;
    end
  end

  // Helper counters for length checks
  logic [11:0] erase_len;
  logic [6:0] prog_len;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      erase_len <= 12'h000;
      prog_len <= 7'h00;
    end else if (clk_en) begin
      erase_len <= flash_erase ? 12'(erase_len + 12'h001) : 12'h000;
      prog_len <= flash_prog_we ? 7'(prog_len + 7'h01) : 7'h00;
    end
  end

  a_start_needs_key: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    $rose(flash_busy) |-> $past(key_armed) && $past(wr_ctrl))
    else $error("operation started without unlock");

  a_erase_code: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    $rose(flash_erase) |-> (ctrl & OP_MASK) == OP_PAGE_ERASE)
    else $error("erase started with wrong code");

  a_erase_page_align: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    flash_erase |-> flash_erase_addr[PAGE_LSB-1:0] == 10'h000)
    else $error("erase address not page aligned");

  // Falls built from $past, so the unknowns before reset cannot fake one
  a_erase_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
    $past(flash_erase) && !flash_erase |-> erase_len == ERASE_CYCLES)
    else $error("erase pulse has wrong length");

  a_row_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    $past(flash_prog_we) && !flash_prog_we |-> prog_len == ROW_WORDS_7 && flash_busy)
    else $error("row did not stream 64 words");

  a_launch_held: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    flash_busy |-> ctrl[LAUNCH_BIT])
    else $error("launch bit low while busy");

  a_launch_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    $past(flash_busy) && !flash_busy |-> !ctrl[LAUNCH_BIT] && done)
    else $error("launch bit not cleared at completion");

  a_high_advance: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE11]
    clk_en && wr_high |=> tbl_offset == 16'($past(tbl_offset) + OFFSET_STEP))
    else $error("offset not advanced after high store");

  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered in one wait");

  a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    clk_en && wr_ctrl && flash_busy |=> refused)
    else $error("control write while busy not refused");

  a_unarmed_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    clk_en && wr_ctrl && !key_armed && !flash_busy |=> !flash_busy)
    else $error("operation started while not armed");

  a_launch_refused: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
    clk_en && wr_ctrl && ctrl_merged[LAUNCH_BIT] && !start_ok && !flash_busy
    |=> refused && !ctrl[LAUNCH_BIT])
    else $error("refused launch left launch bit set");

  a_erase_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    flash_erase && $past(flash_erase) |-> $stable(flash_erase_addr))
    else $error("erase address moved during erase");

  a_prog_addr_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    flash_prog_we && $past(flash_prog_we) && $past(clk_en)
    |-> flash_prog_addr == 24'($past(flash_prog_addr) + 24'h00_0002))
    else $error("row words not streamed in address order");
endmodule

/* File: fsps_write_latch.sv */
module fsps_write_latch
  import fsps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic low_wr,
  input wire logic high_wr,
  input wire logic [5:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] rd_idx,
  output logic [23:0] rd_data
);
  // One row of holding latches; contents are undefined until loaded
  logic [23:0] latch_mem [ROW_WORDS];

  // Low store fills bits 15:0, high store fills the upper byte
  always_ff @(posedge sys_clk) begin
    if (clk_en && low_wr) latch_mem[wr_idx][15:0] <= wr_data; // [RULE11]
    if (clk_en && high_wr) latch_mem[wr_idx][23:16] <= wr_data[7:0]; // [RULE11]
  end

  assign rd_data = latch_mem[rd_idx];
endmodule
